// ===== src/lmfcs_pkg.sv
// package of register map, field layout and codes for the lmfc sync machine
package lmfcs_pkg;
  localparam logic [11:0] ADDR_PAGE = 12'h008;
  localparam logic [11:0] ADDR_IRQ_EN0 = 12'h021;
  localparam logic [11:0] ADDR_IRQ_EN1 = 12'h022;
  localparam logic [11:0] ADDR_IRQ_ST0 = 12'h025;
  localparam logic [11:0] ADDR_IRQ_ST1 = 12'h026;
  localparam logic [11:0] ADDR_WINDOW = 12'h034;
  localparam logic [11:0] ADDR_SNAP_ERR = 12'h038;
  localparam logic [11:0] ADDR_SNAP_FLAG = 12'h039;
  localparam logic [11:0] ADDR_CTRL = 12'h03A;
  localparam logic [11:0] ADDR_STATUS = 12'h03B;
  localparam logic [11:0] ADDR_CUR_ERR = 12'h03C;
  localparam logic [11:0] ADDR_SIDE = 12'h03D;
  localparam logic [11:0] ADDR_HYST_A = 12'h081;
  localparam logic [11:0] ADDR_HYST_B = 12'h082;
  localparam logic [11:0] ADDR_GSUB = 12'h301;
  localparam logic [11:0] ADDR_LSUB = 12'h458;
  localparam int CTRL_ENABLE = 7;
  localparam int CTRL_ARM = 6;
  localparam int CTRL_CLR = 5;
  localparam int ST_BUSY = 7;
  localparam int ST_LOCK = 3;
  localparam int ST_ROT = 2;
  localparam int ST_WLIM = 1;
  localparam int ST_TRIP = 0;
  localparam int IRQ_LOCK = 3;
  localparam int IRQ_ROT = 2;
  localparam int IRQ_TRIP = 1;
  localparam int IRQ_WLIM = 0;
  localparam int SIDE_HIGH = 7;
  localparam int SIDE_LOW = 6;
  localparam logic [3:0] MODE_ONESHOT = 4'h1;
  localparam logic [3:0] MODE_CONT = 4'h2;
  localparam logic [3:0] MODE_MONITOR = 4'h9;
  localparam logic [2:0] SUBCLASS_0 = 3'h0;
  localparam logic [2:0] SUBCLASS_1 = 3'h1;
  localparam logic [7:0] PAGE_RESET = 8'h03;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int LMFC_PERIOD = 16;
  localparam int ROTATE_CYCLES = 4;
endpackage

// ===== src/lmfcs_machine.sv
// lmfc alignment machine for two dacs with paged spi register access
// Contract
// - mode field 0x1 one-shot, 0x2 continuous, 0x9 one-shot then monitor
// - compare lmfc phase to alignment edge, rotate when error beyond window
// - one-shot checks only first edge after arm, later edges ignored
// - continuous needs no arm, checks every edge in subclass 1
// - edges during a rotation are ignored until logic ready again
// - rotate only when measured error exceeds tolerance window
// - window code 0 is half cycle, codes 1 to 7 are one to seven cycles
// - arm clears itself on an edge; arm in continuous changes nothing
// - monitor mode aligns once then only measures and reports
// - present phase error readable, zero after alignment
// - low or high side flag set when error beyond window
// - on alignment, snapshot error and side flags
// - status busy, lock, window bits; lock and window refresh per check
// - rotate and trip bits sticky until clear-sticky written
// - dac0 lock, rotate, trip, window events enabled and w1c status
// - dac1 same four events with own enable and status
// - subclass 0 and 1 only, global and per-link subclass fields
// - subclass 0 uses internal clock edge, keeps dacs synchronized
// - no sync-request error reporting in subclass 0 with one octet
// - single-lane nonmultiple case accepted only with optional ilas
// - two sysref hysteresis registers provided
// - sysref active high, sampled on rising clock edge
// - sync registers paged per dac via page select
module lmfcs_machine #(
  parameter int LMFC_LEN = lmfcs_pkg::LMFC_PERIOD,
  parameter int ROT_LEN = lmfcs_pkg::ROTATE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sysref,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic octet_per_frame_one,
  input wire logic ilas_optional_sent,
  input wire logic sync_request_error,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic [1:0] lmfc_edge,
  output logic sync_request_output,
  output logic single_lane_nonmultiple_alignment_case_ok
);
  import lmfcs_pkg::*;

  typedef enum logic [1:0] {LMFCS_IDLE, LMFCS_ROTATE} lmfcs_state_t;

  logic [7:0] page;
  logic [7:0] hyst_a;
  logic [7:0] hyst_b;
  logic [2:0] gsub;
  logic [2:0] lsub;
  logic sysref_q;
  logic sysref_prev;
  logic [3:0] pclk_cnt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysref_q <= 1'b0;
      sysref_prev <= 1'b0;
      pclk_cnt <= 4'h0;
    end else begin
      sysref_q <= sysref;
      sysref_prev <= sysref_q;
      pclk_cnt <= pclk_cnt + 4'h1;
    end
  end

  wire sysref_rise = sysref_q & ~sysref_prev;
  wire sub1 = (gsub == SUBCLASS_1);
  // alignment edge source chosen by subclass
  wire internal_edge = (pclk_cnt == 4'h0);
  wire align_edge = sub1 ? sysref_rise : internal_edge;


  // global registers, decoded once as named strobes
  wire wr_page = reg_wr && reg_addr == ADDR_PAGE;
  wire wr_hyst_a = reg_wr && reg_addr == ADDR_HYST_A;
  wire wr_hyst_b = reg_wr && reg_addr == ADDR_HYST_B;
  wire wr_gsub = reg_wr && reg_addr == ADDR_GSUB;
  wire wr_lsub = reg_wr && reg_addr == ADDR_LSUB;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      page <= PAGE_RESET;
      hyst_a <= BYTE_ZERO;
      hyst_b <= BYTE_ZERO;
      gsub <= SUBCLASS_1;
      lsub <= SUBCLASS_1;
    end else if (reg_wr) begin
      if (wr_page) page <= reg_wdata;
      if (wr_hyst_a) hyst_a <= reg_wdata;
      if (wr_hyst_b) hyst_b <= reg_wdata;
      if (wr_gsub) gsub <= reg_wdata[2:0];
      if (wr_lsub) lsub <= reg_wdata[7:5];
    end
  end


  // error reporting suppressed for subclass 0 with F = 1
  wire report_off = (gsub == SUBCLASS_0) && octet_per_frame_one;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) sync_request_output <= 1'b1;
    else sync_request_output <= ~(sync_request_error & ~report_off);
  end

  // the single-lane case is only legal when ilas is sent
  assign single_lane_nonmultiple_alignment_case_ok = ilas_optional_sent;


  logic [7:0] rd_dac [2];
  logic [1:0] irq_dac;

  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_dac
      lmfcs_state_t state;
      logic [3:0] mode;
      logic [2:0] window;
      logic enable;
      logic armed;
      logic enable_prev;
      logic [3:0] lmfc_cnt;
      logic [3:0] rot_cnt;
      logic lock;
      logic wlim;
      logic rot_sticky;
      logic trip_sticky;
      logic aligned_once;
      logic [3:0] cur_err;
      logic [1:0] side;
      logic [3:0] snap_err;
      logic [1:0] snap_side;
      logic [3:0] irq_en;
      logic [3:0] irq_st;

      // write decodes; paged writes only reach selected dacs
      wire sel = page[d];
      wire wr_here = reg_wr && sel;
      wire wr_ctrl = wr_here && reg_addr == ADDR_CTRL;
      wire wr_window = wr_here && reg_addr == ADDR_WINDOW;
      wire arm_req = wr_ctrl && reg_wdata[CTRL_ARM];
      wire clr_sticky = wr_ctrl && reg_wdata[CTRL_CLR];
      wire irq_en_wr = reg_wr &&
        reg_addr == (d == 0 ? ADDR_IRQ_EN0 : ADDR_IRQ_EN1);
      wire irq_clr_wr = reg_wr &&
        reg_addr == (d == 0 ? ADDR_IRQ_ST0 : ADDR_IRQ_ST1);
      wire [3:0] irq_clr_mask = irq_clr_wr ? reg_wdata[3:0] : 4'h0;

      // signed error: lmfc position relative to the edge
      // positions in the first half mean the lmfc runs late (high side),
      // the second half is folded back as an early (low side) error
      wire [3:0] pos = lmfc_cnt;
      wire high_side = pos < 4'(LMFC_LEN / 2);
      wire [3:0] mag = high_side ? pos : 4'(4'(LMFC_LEN) - pos);
      // code 0 tolerates only zero whole cycles of error
      wire beyond = (window == 3'h0) ? (mag != 4'h0)
                                     : (mag > {1'b0, window});
      wire mode_ok = mode == MODE_ONESHOT || mode == MODE_CONT ||
                     mode == MODE_MONITOR;
      wire cont_ok = (mode == MODE_CONT) && sub1;
      wire one_ok = (mode == MODE_ONESHOT || mode == MODE_MONITOR) &&
                    armed;
      wire mon_ok = (mode == MODE_MONITOR) && aligned_once;
      wire check = enable && mode_ok && align_edge &&
                   state == LMFCS_IDLE &&
                   (cont_ok || one_ok || mon_ok);
      wire may_rotate = !(mode == MODE_MONITOR && aligned_once);
      wire do_rot = check && beyond && may_rotate;
      wire aligning = check && may_rotate;
      wire [3:0] ev = {check & ~beyond, do_rot, check, check & beyond};
      wire rot_done = (state == LMFCS_ROTATE) &&
                      (rot_cnt == 4'(ROT_LEN - 1));

      // control fields of this dac
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          mode <= 4'h0;
          window <= 3'h0;
          enable <= 1'b0;
          armed <= 1'b0;
          enable_prev <= 1'b0;
        end else begin
          enable_prev <= enable;
          if (wr_window) window <= reg_wdata[2:0];
          if (wr_ctrl) begin
            mode <= reg_wdata[3:0];
            enable <= reg_wdata[CTRL_ENABLE];
          end
          // arm self-clears on any edge while enabled, set wins otherwise
          if (arm_req) armed <= 1'b1;
          else if (align_edge && enable) armed <= 1'b0;
        end
      end

      // lmfc counter and rotation sequencer; edges are ignored while
      // rotating, since a half-done rotation has no valid phase
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          state <= LMFCS_IDLE;
          lmfc_cnt <= 4'h0;
          rot_cnt <= 4'h0;
        end else begin
          lmfc_cnt <= (lmfc_cnt == 4'(LMFC_LEN - 1)) ? 4'h0
                                                     : lmfc_cnt + 4'h1;
          unique case (state)
            LMFCS_IDLE: begin
              if (do_rot) begin
                state <= LMFCS_ROTATE;
                rot_cnt <= 4'h0;
              end
            end
            LMFCS_ROTATE: begin
              rot_cnt <= rot_cnt + 4'h1;
              if (rot_done) begin
                state <= LMFCS_IDLE;
                // edge was seen ROT_LEN+1 cycles ago at zero
                lmfc_cnt <= 4'(ROT_LEN + 1);
              end
            end
            default: state <= LMFCS_IDLE;
          endcase
        end
      end


      // status, error readout and snapshots
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          lock <= 1'b0;
          wlim <= 1'b0;
          rot_sticky <= 1'b0;
          trip_sticky <= 1'b0;
          aligned_once <= 1'b0;
          cur_err <= 4'h0;
          side <= 2'b00;
          snap_err <= 4'h0;
          snap_side <= 2'b00;
        end else begin
          // re-arming outside continuous mode restarts the one alignment
          if (arm_req && mode != MODE_CONT)
            aligned_once <= 1'b0;
          if (check) begin
            lock <= ~beyond;
            wlim <= beyond;
            side <= beyond ? {high_side, ~high_side} : 2'b00;
            cur_err <= aligning ? 4'h0 : mag;
            if (aligning) begin
              aligned_once <= 1'b1;
              snap_err <= cur_err;
              snap_side <= side;
            end
          end
          rot_sticky <= do_rot | (rot_sticky & ~clr_sticky);
          trip_sticky <= check | (trip_sticky & ~clr_sticky);
        end
      end

      // per-dac irq enable and w1c status, set wins
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          irq_en <= 4'h0;
          irq_st <= 4'h0;
        end else begin
          if (irq_en_wr) irq_en <= reg_wdata[3:0];
          irq_st <= ev | (irq_st & ~irq_clr_mask);
        end
      end

      // only enabled status bits reach the shared interrupt line
      assign irq_dac[d] = |(irq_st & irq_en);
      // the lmfc itself, one cycle high per multiframe
      assign lmfc_edge[d] = (lmfc_cnt == 4'h0);

      // busy covers a rotation and an armed or fresh wait for an edge

      wire busy = (state == LMFCS_ROTATE) ||
                  (enable && mode_ok && (armed || (enable && !enable_prev))
                   && mode != MODE_CONT);
      wire [7:0] status = {busy, 3'b000, lock, rot_sticky,
                           wlim, trip_sticky};

      // read mux of this dac's paged registers
      always_comb begin
        rd_dac[d] = BYTE_ZERO;
        unique case (reg_addr)
          ADDR_WINDOW: rd_dac[d] = {5'h00, window};
          ADDR_SNAP_ERR: rd_dac[d] = {4'h0, snap_err};
          ADDR_SNAP_FLAG: rd_dac[d] = {snap_side, 6'h00};
          ADDR_CTRL: rd_dac[d] = {enable, armed, 2'b00, mode};
          ADDR_STATUS: rd_dac[d] = status;
          ADDR_CUR_ERR: rd_dac[d] = {4'h0, cur_err};
          ADDR_SIDE: rd_dac[d] = {side, 6'h00};
          ADDR_IRQ_EN0, ADDR_IRQ_EN1: rd_dac[d] = {4'h0, irq_en};
          ADDR_IRQ_ST0, ADDR_IRQ_ST1: rd_dac[d] = {4'h0, irq_st};
          default: rd_dac[d] = BYTE_ZERO;
        endcase
      end
    end
  endgenerate


  // irq registers are fixed per dac and bypass the page select
  wire is_irq0 = reg_addr == ADDR_IRQ_EN0 || reg_addr == ADDR_IRQ_ST0;
  wire is_irq1 = reg_addr == ADDR_IRQ_EN1 || reg_addr == ADDR_IRQ_ST1;
  // paged reads come from the lowest selected dac
  wire [7:0] paged_rd = is_irq0 ? rd_dac[0] :
                        is_irq1 ? rd_dac[1] :
                        page[0] ? rd_dac[0] :
                        page[1] ? rd_dac[1] : BYTE_ZERO;
  wire [7:0] global_rd =
    (reg_addr == ADDR_PAGE) ? page :
    (reg_addr == ADDR_HYST_A) ? hyst_a :
    (reg_addr == ADDR_HYST_B) ? hyst_b :
    (reg_addr == ADDR_GSUB) ? {5'h00, gsub} :
    (reg_addr == ADDR_LSUB) ? {lsub, 5'h00} : paged_rd;

  // read data is held until the next read strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= BYTE_ZERO;
      irq <= 1'b0;
    end else begin
      if (reg_rd) reg_rdata <= global_rd;
      irq <= |irq_dac;
    end
  end
endmodule // lmfcs_machine

// ===== verif/lmfcs_checker.sv
// port-level assertions for the lmfc sync machine
module lmfcs_checker
  import lmfcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic ilas_optional_sent,
  input wire logic sync_request_error,
  input wire logic [7:0] reg_rdata,
  input wire logic sync_request_output,
  input wire logic single_lane_nonmultiple_alignment_case_ok
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_ilas_case_ok: assert property (
    single_lane_nonmultiple_alignment_case_ok == ilas_optional_sent)
    else $error("ilas case flag wrong");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr == 12'h0FF |=> reg_rdata == BYTE_ZERO)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_sync_out_idle: assert property (
    !sync_request_error |=> sync_request_output)
    else $error("sync request low without error");
  a_hyst_a_back: assert property (
    reg_wr && reg_addr == ADDR_HYST_A ##1 reg_rd && reg_addr == ADDR_HYST_A
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("hyst a readback");
  a_hyst_b_back: assert property (
    reg_wr && reg_addr == ADDR_HYST_B ##1 reg_rd && reg_addr == ADDR_HYST_B
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("hyst b readback");
  a_gsub_back: assert property (
    reg_wr && reg_addr == ADDR_GSUB ##1 reg_rd && reg_addr == ADDR_GSUB
    |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
    else $error("global subclass readback");
  a_lsub_back: assert property (
    reg_wr && reg_addr == ADDR_LSUB ##1 reg_rd && reg_addr == ADDR_LSUB
    |=> reg_rdata[7:5] == $past(reg_wdata[7:5], 2))
    else $error("link subclass readback");
endmodule // lmfcs_checker
bind lmfcs_machine lmfcs_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .ilas_optional_sent(ilas_optional_sent),
  .sync_request_error(sync_request_error), .reg_rdata(reg_rdata),
  .sync_request_output(sync_request_output),
  .single_lane_nonmultiple_alignment_case_ok(
    single_lane_nonmultiple_alignment_case_ok));

// ===== verif/lmfcs_sysref_src.sv
// clock source model placing sysref pulses on its own fixed multiframe grid
module lmfcs_sysref_src (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic sysref
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PERIOD = lmfcs_pkg::LMFC_PERIOD;
  int ph;
  initial sysref = 1'b0;
  // free-running source phase, independent of the receiver's lmfc
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) ph <= 0;
    else ph <= (ph + 1) % PERIOD;
  end
  // one-cycle pulse at source phase d, moved off the rising edge
  task automatic pulse(input int d);
    do @(negedge sys_clk); while (ph != d);
    sysref = 1'b1;
    @(negedge sys_clk);
    sysref = 1'b0;
  endtask
endmodule // lmfcs_sysref_src

// ===== verif/tb.sv
// self-checking testbench for the lmfc sync machine
module tb;
  import lmfcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic f1 = 1'b0, ilas = 1'b0, serr = 1'b0;
  logic sysref, irq, nmc, sro;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [1:0] lmfc_edge;
  int n_mismatch = 0, checks_done = 0;
  lmfcs_machine u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sysref(sysref),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .octet_per_frame_one(f1),
    .ilas_optional_sent(ilas), .sync_request_error(serr),
    .reg_rdata(reg_rdata), .irq(irq), .lmfc_edge(lmfc_edge),
    .sync_request_output(sro),
    .single_lane_nonmultiple_alignment_case_ok(nmc));
  lmfcs_sysref_src u_src (.sys_clk(sys_clk), .rst_n(rst_n),
    .sysref(sysref));
  always #4 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rc(input string n, input logic [11:0] a, input logic [7:0] m,
    input logic [7:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(negedge sys_clk);
    chk(n, e, reg_rdata & m);
  endtask
  // pulse, then leave room for detection, rotation and status update
  task automatic sref(input int d);
    u_src.pulse(d);
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic t_regs;
    rc("page", ADDR_PAGE, 8'hFF, PAGE_RESET);
    rc("unmapped", 12'h0FF, 8'hFF, BYTE_ZERO);
    wr(ADDR_HYST_A, 8'hA5);
    rc("hyst_a", ADDR_HYST_A, 8'hFF, 8'hA5);
    wr(ADDR_HYST_B, 8'h5A);
    rc("hyst_b", ADDR_HYST_B, 8'hFF, 8'h5A);
    wr(ADDR_LSUB, 8'h20);
    rc("link_sub", ADDR_LSUB, 8'hE0, 8'h20);
    wr(ADDR_SNAP_ERR, 8'h0F);
    rc("snap_ro", ADDR_SNAP_ERR, 8'hFF, BYTE_ZERO);
    $display("test regs done");
  endtask
  task automatic t_oneshot;
    wr(ADDR_PAGE, 8'h03);
    wr(ADDR_WINDOW, 8'h00);
    wr(ADDR_CTRL, 8'h81);
    wr(ADDR_CTRL, 8'hC1);
    sref(5);
    rc("os_status", ADDR_STATUS, 8'h87, 8'h07);
    rc("arm_clear", ADDR_CTRL, 8'h40, BYTE_ZERO);
    wr(ADDR_CTRL, 8'hA1);
    rc("sticky_clr", ADDR_STATUS, 8'h05, BYTE_ZERO);
    sref(9);
    rc("os_ignore", ADDR_STATUS, 8'h05, BYTE_ZERO);
    $display("test oneshot done");
  endtask
  task automatic t_monitor;
    wr(ADDR_WINDOW, 8'h01);
    wr(ADDR_CTRL, 8'h89);
    wr(ADDR_CTRL, 8'hC9);
    sref(5);
    sref(5);
    rc("aligned", ADDR_CUR_ERR, 8'h0F, BYTE_ZERO);
    do @(negedge sys_clk); while (u_src.ph != 6);
    chk("lmfc_edge", 8'h03, {6'h00, lmfc_edge});
    wr(ADDR_CTRL, 8'hA9);
    sref(7);
    rc("mon_err", ADDR_CUR_ERR, 8'h0F, 8'h02);
    rc("mon_side", ADDR_SIDE, 8'hC0, 8'h80);
    rc("mon_status", ADDR_STATUS, 8'h07, 8'h03);
    wr(ADDR_CTRL, 8'hC9);
    sref(7);
    rc("snap_err", ADDR_SNAP_ERR, 8'h0F, 8'h02);
    rc("snap_side", ADDR_SNAP_FLAG, 8'hC0, 8'h80);
    rc("post_align", ADDR_CUR_ERR, 8'h0F, BYTE_ZERO);
    $display("test monitor done");
  endtask
  task automatic t_cont;
    wr(ADDR_IRQ_EN0, 8'h04);
    wr(ADDR_CTRL, 8'hA2);
    sref(10);
    rc("cont_status", ADDR_STATUS, 8'h05, 8'h05);
    chk("irq_set", 8'h01, {7'h00, irq});
    rc("irq_stat", ADDR_IRQ_ST0, 8'h04, 8'h04);
    wr(ADDR_IRQ_ST0, 8'h04);
    @(negedge sys_clk);
    chk("irq_clr", BYTE_ZERO, {7'h00, irq});
    wr(ADDR_CTRL, 8'hA2);
    sref(11);
    rc("within_win", ADDR_STATUS, 8'h07, 8'h01);
    wr(ADDR_CTRL, 8'hA3);
    wr(ADDR_CTRL, 8'hC3);
    sref(5);
    rc("reserved", ADDR_STATUS, 8'h05, BYTE_ZERO);
    $display("test continuous done");
  endtask
  task automatic t_sub;
    serr = 1'b1;
    wr(ADDR_GSUB, 8'h01);
    rc("gsub", ADDR_GSUB, 8'h07, 8'h01);
    chk("sro_err", BYTE_ZERO, {7'h00, sro});
    f1 = 1'b1;
    ilas = 1'b1;
    wr(ADDR_GSUB, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk("sro_quiet", 8'h01, {7'h00, sro});
    $display("test subclass done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    t_regs;
    t_oneshot;
    t_monitor;
    t_cont;
    t_sub;
    end_of_test;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test;
  end
endmodule // tb
